// ===== led_fault_pkg.sv
// constants and state codes for the led fault supervisor
package led_fault_pkg;
    localparam int NUM_CH         = 32'h0000_0002;
    localparam int COUNT_W        = 32'h0000_0010;
    localparam int CLK_PERIOD_NS  = 32'h0000_0064; // 100 ns at 10 MHz
    localparam int OPEN_DEG_NS    = 32'h0000_2710; // 10 us
    localparam int SHORT_DEG_NS   = 32'h0000_2710; // 10 us
    localparam int THERM_DEG_NS   = 32'h0000_4E20; // 20 us
    localparam int FAULT_REC_NS   = 32'h0001_86A0; // 100 us
    // least times, rounded up to whole cycles
    localparam logic [COUNT_W-1:0] OPEN_DEG_CYCLES  = COUNT_W'((OPEN_DEG_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [COUNT_W-1:0] SHORT_DEG_CYCLES = COUNT_W'((SHORT_DEG_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [COUNT_W-1:0] THERM_DEG_CYCLES = COUNT_W'((THERM_DEG_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [COUNT_W-1:0] FAULT_REC_CYCLES = COUNT_W'((FAULT_REC_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [COUNT_W-1:0] COUNT_ZERO       = 16'h0000;
    localparam logic [COUNT_W-1:0] COUNT_ONE        = 16'h0001;

    // fault bus supervisor states, one-hot
    typedef enum logic [3:0] {
        ST_OFF     = 4'h1,
        ST_RUN     = 4'h2,
        ST_HOLD    = 4'h4,
        ST_RECOVER = 4'h8
    } bus_state_t;
endpackage

// ===== chan_if.sv
// per-channel conditions and fault flags between supervisor and channel
`timescale 1ns/1ps
interface chan_if;
    logic diag_allowed;   // supply good and chip enabled
    logic open_detect_on; // open detection enabled
    logic dim;            // dimming input, gated by run permission
    logic head_low;       // headroom below open rising threshold
    logic head_ok;        // headroom above open falling threshold
    logic short_low;      // direct or shunt below short threshold
    logic short_ok;       // direct and shunt above short rising threshold
    logic open_fault;
    logic short_fault;
    modport top  (output diag_allowed, open_detect_on, dim, head_low, head_ok, short_low, short_ok,
                  input  open_fault, short_fault);
    modport chan (input  diag_allowed, open_detect_on, dim, head_low, head_ok, short_low, short_ok,
                  output open_fault, short_fault);
endinterface

// ===== deglitch.sv
// deglitch timer: expires a fixed count after run is first seen, unless restart clears it
`timescale 1ns/1ps
module deglitch #(
    parameter logic [led_fault_pkg::COUNT_W-1:0] LIMIT = led_fault_pkg::OPEN_DEG_CYCLES
) (
    // clock and reset
    input  wire logic mclk,
    input  wire logic rst,
    // condition
    input  wire logic run,
    input  wire logic restart,
    output logic      expired
);
    logic [led_fault_pkg::COUNT_W-1:0] cnt;
    logic                              busy;

    always_ff @(posedge mclk) begin
        if (rst || restart) begin
            cnt  <= led_fault_pkg::COUNT_ZERO;
            busy <= 1'b0;
        end else if (busy || run) begin
            busy <= 1'b1;
            if (cnt != LIMIT) begin
                cnt <= cnt + led_fault_pkg::COUNT_ONE;
            end
        end
    end

    assign expired = busy && (cnt == LIMIT);
endmodule

// ===== fault_channel.sv
// per-channel open and short-to-ground detection with retry clearing
`timescale 1ns/1ps
module fault_channel (
    // clock and reset
    input  wire logic mclk,
    input  wire logic rst,
    // channel link
    chan_if.chan      link
);
    logic open_qual;
    logic short_qual;
    logic open_expired;
    logic short_expired;

    assign open_qual  = link.diag_allowed && link.open_detect_on && link.dim && !link.open_fault;
    assign short_qual = link.diag_allowed && link.dim && !link.short_fault;

    deglitch #(.LIMIT(led_fault_pkg::OPEN_DEG_CYCLES)) u_open (
        .mclk    (mclk),
        .rst     (rst),
        .run     (open_qual && link.head_low),
        .restart (!open_qual || link.head_ok),
        .expired (open_expired)
    );

    deglitch #(.LIMIT(led_fault_pkg::SHORT_DEG_CYCLES)) u_short (
        .mclk    (mclk),
        .rst     (rst),
        .run     (short_qual && link.short_low),
        .restart (!short_qual || link.short_ok),
        .expired (short_expired)
    );

    // open fault set, cleared by retry
    always_ff @(posedge mclk) begin
        if (rst) begin
            link.open_fault <= 1'b0;
        end else if (open_expired) begin
            link.open_fault <= 1'b1;
        end else if (!link.diag_allowed || !link.open_detect_on || link.head_ok) begin
            link.open_fault <= 1'b0;
        end
    end

    // short fault set, cleared when retry sees output rise
    always_ff @(posedge mclk) begin
        if (rst) begin
            link.short_fault <= 1'b0;
        end else if (short_expired) begin
            link.short_fault <= 1'b1;
        end else if (!link.diag_allowed || link.short_ok) begin
            link.short_fault <= 1'b0;
        end
    end
endmodule

// ===== led_fault_supervisor.sv
// two-channel led driver fault supervisor with shared fault line
`timescale 1ns/1ps
module led_fault_supervisor (
    // clock and reset
    input  wire logic                             mclk,
    input  wire logic                             rst,
    // supply and enable
    input  wire logic                             supply_above_por,
    input  wire logic                             chip_enable,
    // open-detect enable pin comparators
    input  wire logic                             open_detect_above_high,
    input  wire logic                             open_detect_below_low,
    // per-channel dimming and comparators
    input  wire logic [led_fault_pkg::NUM_CH-1:0] channel_dim_input,
    input  wire logic [led_fault_pkg::NUM_CH-1:0] headroom_below_open_rising,
    input  wire logic [led_fault_pkg::NUM_CH-1:0] headroom_above_open_falling,
    input  wire logic [led_fault_pkg::NUM_CH-1:0] direct_output_below_short,
    input  wire logic [led_fault_pkg::NUM_CH-1:0] shunt_output_below_short,
    input  wire logic [led_fault_pkg::NUM_CH-1:0] direct_output_above_short_rising,
    input  wire logic [led_fault_pkg::NUM_CH-1:0] shunt_output_above_short_rising,
    // junction temperature comparators
    input  wire logic                             temp_at_shutdown,
    input  wire logic                             temp_below_recovery,
    // fault line pin: comparators, output, enable, weak pull-up
    input  wire logic                             fault_line_above_high,
    input  wire logic                             fault_line_below_low,
    output logic                                  fault_line_out,
    output logic                                  fault_line_oe,
    output logic                                  fault_line_pullup_on,
    // channel drive
    output logic      [led_fault_pkg::NUM_CH-1:0] channel_regulate,
    output logic      [led_fault_pkg::NUM_CH-1:0] channel_retry,
    // status
    output logic      [led_fault_pkg::NUM_CH-1:0] open_fault,
    output logic      [led_fault_pkg::NUM_CH-1:0] short_fault,
    output logic                                  thermal_shutdown,
    output logic                                  low_current_mode
);
    led_fault_pkg::bus_state_t             state;
    led_fault_pkg::bus_state_t             next_state;
    logic                                  local_rst;
    logic                                  active;
    logic                                  open_on;
    logic                                  line_low;
    logic                                  had_local;
    logic                                  therm_expired;
    logic                                  local_fault;
    logic                                  run_ok;
    logic                                  rec_done;
    logic [led_fault_pkg::COUNT_W-1:0]     rec_cnt;
    logic [led_fault_pkg::NUM_CH-1:0]      ch_open;
    logic [led_fault_pkg::NUM_CH-1:0]      ch_short;
    logic [led_fault_pkg::NUM_CH-1:0]      next_regulate;
    logic [led_fault_pkg::NUM_CH-1:0]      next_retry;

    // supply below power-on threshold clears everything
    assign local_rst = rst || !supply_above_por;
    assign active    = supply_above_por && chip_enable;

    always_ff @(posedge mclk) begin
        if (local_rst) begin
            open_on <= 1'b0;
        end else if (open_detect_above_high) begin
            open_on <= 1'b1;
        end else if (open_detect_below_low) begin
            open_on <= 1'b0;
        end
    end

    always_ff @(posedge mclk) begin
        if (local_rst) begin
            line_low <= 1'b0;
        end else if (fault_line_below_low) begin
            line_low <= 1'b1;
        end else if (fault_line_above_high) begin
            line_low <= 1'b0;
        end
    end

    // thermal deglitch, counted only with chip enable
    deglitch #(.LIMIT(led_fault_pkg::THERM_DEG_CYCLES)) u_therm (
        .mclk    (mclk),
        .rst     (local_rst),
        .run     (chip_enable && temp_at_shutdown && !thermal_shutdown),
        .restart (!chip_enable || !temp_at_shutdown),
        .expired (therm_expired)
    );

    // shutdown until below threshold minus hysteresis
    always_ff @(posedge mclk) begin
        if (local_rst) begin
            thermal_shutdown <= 1'b0;
        end else if (therm_expired) begin
            thermal_shutdown <= 1'b1;
        end else if (!chip_enable || temp_below_recovery) begin
            thermal_shutdown <= 1'b0;
        end
    end

    // channels run only in the normal bus state
    assign run_ok = state == led_fault_pkg::ST_RUN && !thermal_shutdown;

    // per-channel detectors
    generate
        for (genvar i = 0; i < led_fault_pkg::NUM_CH; i++) begin : g_ch
            chan_if link ();

            // dimming low gates current and diagnostics
            assign link.diag_allowed   = active;
            assign link.open_detect_on = open_on;
            assign link.dim            = channel_dim_input[i] && run_ok;
            assign link.head_low       = headroom_below_open_rising[i];
            assign link.head_ok        = headroom_above_open_falling[i];
            assign link.short_low      = direct_output_below_short[i] || shunt_output_below_short[i];
            assign link.short_ok       = direct_output_above_short_rising[i] && shunt_output_above_short_rising[i];
            assign ch_open[i]          = link.open_fault;
            assign ch_short[i]         = link.short_fault;

            fault_channel u_chan (
                .mclk (mclk),
                .rst  (local_rst),
                .link (link.chan)
            );
        end
    endgenerate

    // any fault raised by this device
    assign local_fault = (|ch_open) || (|ch_short) || thermal_shutdown;

    // recovery interval finished
    assign rec_done = rec_cnt == led_fault_pkg::FAULT_REC_CYCLES;

    // fault bus supervisor transitions
    always_comb begin
        next_state = state;
        case (state)
            led_fault_pkg::ST_OFF: begin
                if (active) begin
                    next_state = led_fault_pkg::ST_RUN;
                end
            end
            led_fault_pkg::ST_RUN: begin
                if (!active) begin
                    next_state = led_fault_pkg::ST_OFF;
                end else if (line_low) begin
                    next_state = led_fault_pkg::ST_HOLD;
                end
            end
            led_fault_pkg::ST_HOLD: begin
                if (!active) begin
                    next_state = led_fault_pkg::ST_OFF;
                end else if (!line_low) begin
                    // delay after release when local fault was seen
                    next_state = (had_local || local_fault) ? led_fault_pkg::ST_RECOVER
                                                             : led_fault_pkg::ST_RUN;
                end
            end
            led_fault_pkg::ST_RECOVER: begin
                if (!active) begin
                    next_state = led_fault_pkg::ST_OFF;
                end else if (line_low) begin
                    next_state = led_fault_pkg::ST_HOLD;
                end else if (rec_done) begin
                    next_state = led_fault_pkg::ST_RUN;
                end
            end
            default: begin
                next_state = led_fault_pkg::ST_OFF;
            end
        endcase
    end

    // state register
    always_ff @(posedge mclk) begin
        if (local_rst) begin
            state <= led_fault_pkg::ST_OFF;
        end else begin
            state <= next_state;
        end
    end

    // remember a local fault while the line is held
    always_ff @(posedge mclk) begin
        if (local_rst) begin
            had_local <= 1'b0;
        end else if (state == led_fault_pkg::ST_HOLD && local_fault) begin
            had_local <= 1'b1;
        end else if (state == led_fault_pkg::ST_RUN) begin
            had_local <= 1'b0;
        end
    end

    // recovery counter restarts when line drops again
    always_ff @(posedge mclk) begin
        if (local_rst || state != led_fault_pkg::ST_RECOVER || line_low) begin
            rec_cnt <= led_fault_pkg::COUNT_ZERO;
        end else if (!rec_done) begin
            rec_cnt <= rec_cnt + led_fault_pkg::COUNT_ONE;
        end
    end

    // channel drive decisions
    always_comb begin
        next_regulate = '0;
        next_retry    = '0;
        for (int i = 0; i < led_fault_pkg::NUM_CH; i++) begin
            next_regulate[i] = run_ok && channel_dim_input[i] && !ch_open[i] && !ch_short[i];
            // retry ignoring dimming, stopped by thermal shutdown
            next_retry[i]    = active && !thermal_shutdown && (ch_short[i] || (ch_open[i] && open_on));
        end
    end

    always_ff @(posedge mclk) begin
        if (local_rst) begin
            channel_regulate <= '0;
            channel_retry    <= '0;
        end else begin
            channel_regulate <= next_regulate;
            channel_retry    <= next_retry;
        end
    end

    // status copies
    always_ff @(posedge mclk) begin
        if (local_rst) begin
            open_fault  <= '0;
            short_fault <= '0;
        end else begin
            open_fault  <= ch_open;
            short_fault <= ch_short;
        end
    end

    // fault line pull-down and weak pull-up
    always_ff @(posedge mclk) begin
        if (local_rst) begin
            fault_line_oe        <= 1'b0;
            fault_line_pullup_on <= 1'b0;
        end else begin
            fault_line_oe        <= local_fault;
            fault_line_pullup_on <= !local_fault;
        end
    end

    // open-drain: only ever drives low
    assign fault_line_out = 1'b0;

    // low-current fault mode while the line is low
    always_ff @(posedge mclk) begin
        if (local_rst) begin
            low_current_mode <= 1'b0;
        end else begin
            low_current_mode <= line_low;
        end
    end
endmodule

// ===== led_fault_supervisor_asserts.sv
// concurrent checks on the led fault supervisor ports
`timescale 1ns/1ps
module led_fault_supervisor_asserts #(
    parameter int N = led_fault_pkg::NUM_CH
) (
    // clock and reset
    input wire logic         mclk,
    input wire logic         rst,
    // inputs watched
    input wire logic         supply_above_por,
    input wire logic [N-1:0] channel_dim_input,
    input wire logic [N-1:0] headroom_below_open_rising,
    input wire logic [N-1:0] direct_output_below_short,
    input wire logic [N-1:0] shunt_output_below_short,
    input wire logic         fault_line_below_low,
    // outputs watched
    input wire logic         fault_line_out,
    input wire logic         fault_line_oe,
    input wire logic         fault_line_pullup_on,
    input wire logic [N-1:0] channel_regulate,
    input wire logic [N-1:0] channel_retry,
    input wire logic [N-1:0] open_fault,
    input wire logic [N-1:0] short_fault,
    input wire logic         thermal_shutdown,
    input wire logic         low_current_mode
);
    default clocking @(posedge mclk); endclocking
    default disable iff (rst);

    a_open_deglitch: assert property ($rose(open_fault[0]) |->
        $past(headroom_below_open_rising[0], 2) && $past(headroom_below_open_rising[0], 90)
        && $past(channel_dim_input[0], 2)) else $error("open fault without held low headroom");
    a_short_deglitch: assert property ($rose(short_fault[1]) |->
        $past(direct_output_below_short[1] | shunt_output_below_short[1], 90))
        else $error("short fault without held short level");
    // fault sinks line, sink trails the thermal flag by one edge
    a_fault_sinks_line: assert property ((|open_fault) || (|short_fault) || $past(thermal_shutdown)
        |-> fault_line_oe) else $error("fault present but line not sunk");
    a_pullup_weak: assert property (!$past(rst) && !$past(rst, 2) && !$past(rst, 3)
        && $past(supply_above_por) && $past(supply_above_por, 2) && $past(supply_above_por, 3)
        |-> fault_line_pullup_on == !fault_line_oe) else $error("pull-up not inverse of sink");
    a_line_data_zero: assert property (fault_line_out == 1'h0)
        else $error("fault line data not low");
    a_failed_no_reg: assert property (((open_fault | short_fault) & channel_regulate) == '0)
        else $error("failed channel still regulating");
    a_thermal_off: assert property (thermal_shutdown [*2] |->
        channel_regulate == '0 && channel_retry == '0) else $error("outputs on in thermal shutdown");
    a_line_low_mode: assert property ((fault_line_below_low && supply_above_por) [*3]
        |-> low_current_mode) else $error("line low without low current mode");
    a_ext_pull_off: assert property ((fault_line_below_low && supply_above_por) [*5]
        |-> channel_regulate == '0) else $error("regulating while line held low");
    a_por_off: assert property (!supply_above_por [*2] |->
        {channel_regulate, channel_retry, fault_line_oe, fault_line_pullup_on} == '0)
        else $error("outputs active below power-on level");
    a_dim_low_off: assert property ((!channel_dim_input[0]) [*3] |-> !channel_regulate[0])
        else $error("channel regulating with dimming low");
endmodule

bind led_fault_supervisor led_fault_supervisor_asserts i_led_fault_supervisor_asserts (.*);

// ===== fault_peer.sv
// peer driver model sharing the wired fault line
`timescale 1ns/1ps
module fault_peer (
    // clock
    input wire logic mclk,
    // peer command and device sink
    input wire logic pull_cmd,
    input wire logic dev_oe,
    input wire logic dev_out,
    // line comparators seen by the device
    output logic     line_above_high,
    output logic     line_below_low
);
    logic peer_sink;
    logic line_low;
    // peer sink moves just after the edge
    always_ff @(posedge mclk) begin
        peer_sink <= pull_cmd;
    end
    // wired line, peer pull-ups keep it high
    assign line_low        = peer_sink || (dev_oe && !dev_out);
    assign line_above_high = !line_low;
    assign line_below_low  = line_low;
endmodule

// ===== led_fault_supervisor_tb.sv
// self-checking bench for the led fault supervisor
`timescale 1ns/1ps
module led_fault_supervisor_tb;
    logic       mclk, rst, supply, chip_en, od_high, od_low, t_at, t_rec, pull, line_hi, line_lo;
    logic       line_out, line_oe, pu_on, thermal, lcm;
    logic [1:0] dim, h_low, h_ok, d_lo, s_lo, d_hi, s_hi, reg_on, retry, open_f, short_f;
    int         fails, checked;

    led_fault_supervisor i_led_fault_supervisor (.mclk(mclk), .rst(rst), .supply_above_por(supply),
        .chip_enable(chip_en), .open_detect_above_high(od_high), .open_detect_below_low(od_low),
        .channel_dim_input(dim), .headroom_below_open_rising(h_low), .headroom_above_open_falling(h_ok),
        .direct_output_below_short(d_lo), .shunt_output_below_short(s_lo),
        .direct_output_above_short_rising(d_hi), .shunt_output_above_short_rising(s_hi),
        .temp_at_shutdown(t_at), .temp_below_recovery(t_rec), .fault_line_above_high(line_hi),
        .fault_line_below_low(line_lo), .fault_line_out(line_out), .fault_line_oe(line_oe),
        .fault_line_pullup_on(pu_on), .channel_regulate(reg_on), .channel_retry(retry),
        .open_fault(open_f), .short_fault(short_f), .thermal_shutdown(thermal), .low_current_mode(lcm));
    fault_peer i_fault_peer (.mclk(mclk), .pull_cmd(pull), .dev_oe(line_oe), .dev_out(line_out),
        .line_above_high(line_hi), .line_below_low(line_lo));

    // clock generation
    initial begin
        mclk = 1'h0;
        forever #50 mclk = ~mclk;
    end
    // wait cycles, then settle past the edge
    task automatic cyc(input int n);
        repeat (n) @(posedge mclk);
        #10;
    endtask
    // compare and count
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        checked++;
        if (seen !== exp) begin
            fails++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    // verdict and end of run
    task automatic close_out;
        $display("comparisons %0d mismatches %0d", checked, fails);
        if (fails == 0 && checked > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    // open fault, hold, clear and recovery
    task automatic t_open;
        @(posedge mclk);
        h_low <= 2'h1;
        h_ok  <= 2'h2;
        cyc(95);
        check(open_f, 2'h0);
        cyc(10);
        check(open_f, 2'h1);
        check({reg_on[0], retry[0], line_oe}, 3'h3);
        cyc(5);
        check({lcm, reg_on[1]}, 2'h2);
        @(posedge mclk);
        h_low <= 2'h0;
        h_ok  <= 2'h3;
        cyc(6);
        check({open_f, line_oe}, 3'h0);
        cyc(900);
        check(reg_on, 2'h0);
        cyc(120);
        check(reg_on, 2'h3);
    endtask
    // timer restart, detection gating
    task automatic t_gated;
        @(posedge mclk);
        h_low <= 2'h1;
        h_ok  <= 2'h2;
        cyc(70);
        @(posedge mclk);
        h_ok  <= 2'h3;
        @(posedge mclk);
        h_ok  <= 2'h2;
        cyc(70);
        check(open_f, 2'h0);
        // enable held low while headroom sits low
        @(posedge mclk);
        od_high <= 1'h0;
        od_low  <= 1'h1;
        cyc(150);
        check(open_f, 2'h0);
        @(posedge mclk);
        od_high <= 1'h1;
        od_low  <= 1'h0;
        dim     <= 2'h2;
        cyc(150);
        check({open_f, reg_on[0]}, 3'h0);
        @(posedge mclk);
        h_low <= 2'h0;
        h_ok  <= 2'h3;
        dim   <= 2'h3;
    endtask
    // short with open detection off
    task automatic t_short;
        @(posedge mclk);
        od_high <= 1'h0;
        od_low  <= 1'h1;
        d_lo    <= 2'h2;
        d_hi    <= 2'h1;
        cyc(95);
        check(short_f, 2'h0);
        cyc(10);
        check({short_f, reg_on[1], retry[1]}, 4'h9);
        @(posedge mclk);
        dim  <= 2'h1;
        s_lo <= 2'h2;
        s_hi <= 2'h1;
        cyc(3);
        check(retry[1], 1'h1);
        @(posedge mclk);
        d_lo    <= 2'h0;
        d_hi    <= 2'h3;
        dim     <= 2'h3;
        od_high <= 1'h1;
        od_low  <= 1'h0;
        cyc(3);
        // shunt still low keeps the fault
        check(short_f, 2'h2);
        @(posedge mclk);
        s_lo <= 2'h0;
        s_hi <= 2'h3;
        cyc(1100);
        check({short_f, reg_on}, 4'h3);
    endtask
    // overtemperature shutdown and recovery
    task automatic t_thermal;
        @(posedge mclk);
        t_at  <= 1'h1;
        t_rec <= 1'h0;
        cyc(195);
        check(thermal, 1'h0);
        cyc(10);
        check({thermal, line_oe, reg_on, retry}, 6'h30);
        @(posedge mclk);
        t_at  <= 1'h0;
        t_rec <= 1'h1;
        cyc(1100);
        check({thermal, reg_on}, 3'h3);
    endtask
    // peer pulls line, then supply drop
    task automatic t_bus_supply;
        @(posedge mclk);
        pull <= 1'h1;
        cyc(6);
        check({lcm, reg_on, pu_on, line_oe}, 5'h12);
        @(posedge mclk);
        pull <= 1'h0;
        cyc(6);
        check({lcm, reg_on}, 3'h3);
        @(posedge mclk);
        supply <= 1'h0;
        cyc(3);
        check({reg_on, pu_on, line_oe}, 4'h0);
        @(posedge mclk);
        supply <= 1'h1;
        cyc(6);
        check({reg_on, pu_on}, 3'h7);
        // chip disabled: outputs off, no thermal count
        @(posedge mclk);
        chip_en <= 1'h0;
        t_at    <= 1'h1;
        cyc(250);
        check({thermal, reg_on, line_oe}, 4'h0);
        @(posedge mclk);
        chip_en <= 1'h1;
        t_at    <= 1'h0;
        cyc(6);
        check({thermal, reg_on}, 3'h3);
    endtask
    // watchdog
    initial begin
        #2_000_000;
        fails++;
        close_out();
    end
    // main sequence
    initial begin
        {rst, supply, chip_en, od_high, t_rec} = 5'h1F;
        {od_low, t_at, pull} = 3'h0;
        {dim, h_ok, d_hi, s_hi} = 8'hFF;
        {h_low, d_lo, s_lo} = 6'h00;
        fails = 0;
        checked = 0;
        repeat (6) @(posedge mclk);
        rst <= 1'h0;
        cyc(5);
        check({reg_on, pu_on, line_oe, line_out}, 5'h1C);
        t_open();
        t_gated();
        t_short();
        t_thermal();
        t_bus_supply();
        close_out();
    end
endmodule
